// *** tb_voltage_monitor_fault_response.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_voltage_monitor_fault_response;
    import vmfr_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [18:0] level = '0;
    logic [18:0] cmp_raw;
    logic ref_mismatch = 1'b0;
    logic battery_ov_mask = 1'b0;
    logic core_fault_action_en = 1'b1;
    logic [7:0] sa, sb, ss;
    vmfr_state_type state;
    logic regs_off, por, rst_n, drv;
    logic [29:0] obs;
    logic [31:0] rng = 32'h0000373F;
    int corner_idx[3] = '{1, 8, 9};
    int miscompares = 0;
    int tests_run = 0;

    always #5 ref_clk = ~ref_clk;

    vmfr_cmp_model u_vmfr_cmp_model (.ref_clk(ref_clk), .level(level), .cmp_raw(cmp_raw));

    vmfr_monitor u_vmfr_monitor (
        .ref_clk(ref_clk), .reset(reset), .cmp_raw(cmp_raw), .ref_mismatch(ref_mismatch),
        .battery_ov_mask(battery_ov_mask), .core_fault_action_en(core_fault_action_en),
        .monitor_status_a(sa), .monitor_status_b(sb), .safety_status_a(ss), .state(state),
        .regulators_off(regs_off), .power_on_reset(por), .mcu_reset_n(rst_n),
        .drive_enable(drv)
    );

    // Everything the block shows, packed for one compare
    assign obs = {sa, sb, ss, state, rst_n, drv, por, regs_off};

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Expected outputs for a settled set of faults and the current configuration
    function automatic logic [29:0] exp_of(input logic [18:0] f);
        logic sby, rst, off;
        vmfr_state_type st;
        sby = f[0] | f[12] | f[14] | f[15] | f[16] | f[17] | f[18] | ref_mismatch;
        rst = (f[1] & ~battery_ov_mask) | f[6] | (f[8] & core_fault_action_en);
        off = f[5] | f[7] | (f[9] & core_fault_action_en);
        st = sby ? VMFR_STANDBY : (rst ? VMFR_RESET : VMFR_ACTIVE);
        return {f[1], f[0], f[12], f[14], f[13], f[15] | f[16], 2'h0,
                f[3], f[2], f[5], f[4], f[7], f[6], f[9], f[8],
                2'h0, f[10], f[11], 4'h0, st, ~(sby | rst), ~(sby | rst | off),
                f[15] | f[16] | f[17] | f[18], f[14]};
    endfunction

    task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // New fault set: old outputs must hold inside the filter time, new ones after it
    task automatic apply(input logic [18:0] f);
        logic [18:0] old;
        old = level;
        level = f;
        tick(1000);
        chk(obs, exp_of(old));
        tick(520);
        chk(obs, exp_of(f));
    endtask

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog well above the expected run of about 80000 cycles
    initial begin
        repeat (95000) @(posedge ref_clk);
        miscompares++;
        complete_run;
    end

    initial begin
        tick(20);
        chk(obs, {24'h000000, VMFR_STANDBY, 4'h0});
        reset = 1'b0;
        tick(2);
        chk(obs, exp_of(19'h00000));
        // Every comparator alone, configuration random except where it matters
        for (int i = 0; i < 19; i++) begin
            rng = xs(rng);
            battery_ov_mask = rng[0];
            core_fault_action_en = rng[1];
            if (i == 1 || i == 8 || i == 9) begin
                battery_ov_mask = 1'b0;
                core_fault_action_en = 1'b1;
            end
            apply(19'h00001 << i);
            apply(19'h00000);
        end
        // Masked battery OV and disabled core actions
        battery_ov_mask = 1'b1;
        core_fault_action_en = 1'b0;
        foreach (corner_idx[k]) begin
            apply(19'h00001 << corner_idx[k]);
            apply(19'h00000);
        end
        // Reset beats drive-off, then a random mix
        battery_ov_mask = 1'b0;
        core_fault_action_en = 1'b1;
        apply(19'h000E0);
        apply(19'h00000);
        rng = xs(rng);
        apply(rng[18:0]);
        apply(19'h00000);
        // A fault shorter than the filter leaves no trace
        level = 19'h00040;
        tick(1400);
        chk(obs, exp_of(19'h00000));
        level = 19'h00000;
        tick(300);
        chk(obs, exp_of(19'h00000));
        // Reference mismatch takes two edges each way
        ref_mismatch = 1'b1;
        tick(3);
        chk(obs, exp_of(19'h00000));
        ref_mismatch = 1'b0;
        tick(3);
        chk(obs, exp_of(19'h00000));
        // Reset in mid-fault clears the filters; the fault must persist anew
        apply(19'h00001);
        reset = 1'b1;
        tick(2);
        chk(obs, {24'h000000, VMFR_STANDBY, 4'h0});
        reset = 1'b0;
        tick(2);
        chk(obs, exp_of(19'h00000));
        tick(1500);
        chk(obs, exp_of(19'h00001));
        apply(19'h00000);
        complete_run;
    end
endmodule // tb_voltage_monitor_fault_response
`default_nettype wire

// *** vmfr_cmp_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module vmfr_cmp_model (
    // Clock
    input wire logic ref_clk,
    // Requested rail condition, 1 = out of band
    input wire logic [18:0] level,
    // Comparator results towards the monitor
    output logic [18:0] cmp_raw
);
    logic [18:0] seen = '0;
    logic [18:0] diff = '0;
    logic [2:0] bounce = '0;

    // Real comparators chatter around a crossing, so each change bounces a few cycles
    always_ff @(posedge ref_clk) begin
        seen <= level;
        if (level != seen) begin
            diff <= level ^ seen;
            bounce <= 3'h4;
        end else if (bounce != 3'h0) begin
            bounce <= bounce - 3'h1;
        end
    end

    // Odd bounce counts show the old level again
    assign cmp_raw = bounce[0] ? (level ^ diff) : level;
endmodule // vmfr_cmp_model
`default_nettype wire

// *** vmfr_consts.svh ***
`ifndef VMFR_CONSTS_SVH
`define VMFR_CONSTS_SVH
// Status bit positions
`define VMFR_A_BAT_OV 3'd7
`define VMFR_A_BAT_UV 3'd6
`define VMFR_A_PH_OV 3'd5
`define VMFR_A_PL_OV 3'd4
`define VMFR_A_PL_UV 3'd3
`define VMFR_A_MA 3'd2
`define VMFR_B_PRE_OV 3'd7
`define VMFR_B_PRE_UV 3'd6
`define VMFR_B_CAN_OV 3'd5
`define VMFR_B_CAN_UV 3'd4
`define VMFR_B_IO_OV 3'd3
`define VMFR_B_IO_UV 3'd2
`define VMFR_B_CORE_OV 3'd1
`define VMFR_B_CORE_UV 3'd0
`define VMFR_S_SNS_UV 3'd5
`define VMFR_S_SNS_OV 3'd4
// Comparator index of each monitored input
`define VMFR_NUM_CMP 19
`define VMFR_I_BAT_UV 0
`define VMFR_I_BAT_OV 1
`define VMFR_I_PRE_UV 2
`define VMFR_I_PRE_OV 3
`define VMFR_I_CAN_UV 4
`define VMFR_I_CAN_OV 5
`define VMFR_I_IO_UV 6
`define VMFR_I_IO_OV 7
`define VMFR_I_CORE_UV 8
`define VMFR_I_CORE_OV 9
`define VMFR_I_SNS_UV 10
`define VMFR_I_SNS_OV 11
`define VMFR_I_PH_OV 12
`define VMFR_I_PL_UV 13
`define VMFR_I_PL_OV 14
`define VMFR_I_MA_UV 15
`define VMFR_I_MA_OV 16
`define VMFR_I_AN_UV 17
`define VMFR_I_DIG 18
// Glitch filter: 15 us least time at 10 ns period
`define VMFR_FILT_NS 15000
`define VMFR_CLK_NS 10
`define VMFR_FILT_CYC ((`VMFR_FILT_NS + `VMFR_CLK_NS - 1) / `VMFR_CLK_NS)
`define VMFR_FILT_W 11
`endif

// *** vmfr_filt_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface vmfr_filt_if;
    logic [18:0] raw;
    logic [18:0] clean;
    modport src (output raw, input clean);
    modport flt (input raw, output clean);
endinterface
`default_nettype wire

// *** vmfr_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vmfr_consts.svh"
module vmfr_filter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Comparator lines
    vmfr_filt_if.flt fi
);
    logic [`VMFR_FILT_W-1:0] cnt [`VMFR_NUM_CMP];
    logic [`VMFR_FILT_W-1:0] next_cnt [`VMFR_NUM_CMP];
    logic [`VMFR_NUM_CMP-1:0] clean;
    logic [`VMFR_NUM_CMP-1:0] next_clean;
    localparam logic [`VMFR_FILT_W-1:0] LIMIT = `VMFR_FILT_W'(`VMFR_FILT_CYC);
    genvar g;
    generate
        for (g = 0; g < `VMFR_NUM_CMP; g++) begin : g_ch
            // Output follows input only after it differs for the whole filter time
            always_comb begin
                next_cnt[g] = '0;
                next_clean[g] = clean[g];
                if (fi.raw[g] != clean[g]) begin
                    if (cnt[g] == LIMIT - 1'b1) begin
                        next_clean[g] = fi.raw[g];
                    end else begin
                        next_cnt[g] = cnt[g] + 1'b1;
                    end
                end
            end
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    cnt[g] <= '0;
                    clean[g] <= 1'b0;
                end else begin
                    cnt[g] <= next_cnt[g];
                    clean[g] <= next_clean[g];
                end
            end
        end
    endgenerate
    assign fi.clean = clean;
endmodule // vmfr_filter
`default_nettype wire

// *** vmfr_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vmfr_consts.svh"
module vmfr_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Raw comparator results, one bit per monitor input
    input wire logic [18:0] cmp_raw,
    input wire logic ref_mismatch,
    // Configuration
    input wire logic battery_ov_mask,
    input wire logic core_fault_action_en,
    // Status
    output logic [7:0] monitor_status_a,
    output logic [7:0] monitor_status_b,
    output logic [7:0] safety_status_a,
    output vmfr_pkg::vmfr_state_type state,
    output logic regulators_off,
    // Actions
    output logic power_on_reset,
    output logic mcu_reset_n,
    output logic drive_enable
);
    import vmfr_pkg::*;
    vmfr_filt_if fi ();
    logic [18:0] c;
    logic ref_clean;
    logic [7:0] next_sa, next_sb, next_ss;
    logic want_stby, want_rst, want_drv_off, want_por;
    vmfr_state_type next_state;
    logic next_rst_n, next_drv, next_por, next_regoff;
    // All comparator lines pass the shared glitch filter
    assign fi.raw = cmp_raw;
    vmfr_filter u_filt (
        .ref_clk(ref_clk),
        .reset(reset),
        .fi(fi)
    );
    assign c = fi.clean;
    // Reference fault takes one register stage; the window compare itself is analog
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ref_clean <= 1'b0;
        end else begin
            ref_clean <= ref_mismatch;
        end
    end
    // Status flags track the filtered comparators level by level
    always_comb begin
        next_sa = 8'h00;
        next_sb = 8'h00;
        next_ss = 8'h00;
        next_sa[`VMFR_A_BAT_UV] = c[`VMFR_I_BAT_UV];
        next_sa[`VMFR_A_BAT_OV] = c[`VMFR_I_BAT_OV];
        next_sa[`VMFR_A_PH_OV] = c[`VMFR_I_PH_OV];
        next_sa[`VMFR_A_PL_OV] = c[`VMFR_I_PL_OV];
        next_sa[`VMFR_A_PL_UV] = c[`VMFR_I_PL_UV];
        next_sa[`VMFR_A_MA] = c[`VMFR_I_MA_UV] | c[`VMFR_I_MA_OV];
        next_sb[`VMFR_B_PRE_UV] = c[`VMFR_I_PRE_UV];
        next_sb[`VMFR_B_PRE_OV] = c[`VMFR_I_PRE_OV];
        next_sb[`VMFR_B_CAN_UV] = c[`VMFR_I_CAN_UV];
        next_sb[`VMFR_B_CAN_OV] = c[`VMFR_I_CAN_OV];
        next_sb[`VMFR_B_IO_UV] = c[`VMFR_I_IO_UV];
        next_sb[`VMFR_B_IO_OV] = c[`VMFR_I_IO_OV];
        next_sb[`VMFR_B_CORE_UV] = c[`VMFR_I_CORE_UV];
        next_sb[`VMFR_B_CORE_OV] = c[`VMFR_I_CORE_OV];
        next_ss[`VMFR_S_SNS_UV] = c[`VMFR_I_SNS_UV];
        next_ss[`VMFR_S_SNS_OV] = c[`VMFR_I_SNS_OV];
    end
    // Action requests per severity; preregulator, CAN UV, sensor, pump low UV request nothing
    always_comb begin
        want_por = c[`VMFR_I_MA_UV] | c[`VMFR_I_MA_OV] | c[`VMFR_I_AN_UV]
            | c[`VMFR_I_DIG];
        want_stby = want_por | c[`VMFR_I_BAT_UV] | c[`VMFR_I_PH_OV]
            | c[`VMFR_I_PL_OV] | ref_clean;
        want_rst = (c[`VMFR_I_BAT_OV] & ~battery_ov_mask)
            | c[`VMFR_I_IO_UV]
            | (c[`VMFR_I_CORE_UV] & core_fault_action_en);
        want_drv_off = c[`VMFR_I_CAN_OV] | c[`VMFR_I_IO_OV]
            | (c[`VMFR_I_CORE_OV] & core_fault_action_en);
    end
    // Most severe request wins; faults clear return the device to active
    always_comb begin
        next_por = want_por;
        next_regoff = c[`VMFR_I_PL_OV];
        if (want_stby) begin
            next_state = VMFR_STANDBY;
        end else if (want_rst) begin
            next_state = VMFR_RESET;
        end else begin
            next_state = VMFR_ACTIVE;
        end
        case (next_state)
            VMFR_STANDBY: begin
                next_rst_n = 1'b0;
                next_drv = 1'b0;
            end
            VMFR_RESET: begin
                next_rst_n = 1'b0;
                next_drv = 1'b0;
            end
            VMFR_ACTIVE: begin
                next_rst_n = 1'b1;
                next_drv = ~want_drv_off;
            end
            default: begin
                next_rst_n = 1'b0;
                next_drv = 1'b0;
            end
        endcase
    end
    // Outputs held in reset-safe state: reset low, drive disabled
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            monitor_status_a <= 8'h00;
            monitor_status_b <= 8'h00;
            safety_status_a <= 8'h00;
            state <= VMFR_STANDBY;
            regulators_off <= 1'b0;
            power_on_reset <= 1'b0;
            mcu_reset_n <= 1'b0;
            drive_enable <= 1'b0;
        end else begin
            monitor_status_a <= next_sa;
            monitor_status_b <= next_sb;
            safety_status_a <= next_ss;
            state <= next_state;
            regulators_off <= next_regoff;
            power_on_reset <= next_por;
            mcu_reset_n <= next_rst_n;
            drive_enable <= next_drv;
        end
    end
    // Checks
    sequence s_stby_req;
        c[`VMFR_I_BAT_UV] || c[`VMFR_I_PH_OV] || c[`VMFR_I_PL_OV];
    endsequence
    property p_stby;
        @(posedge ref_clk) disable iff (reset)
        s_stby_req |=> state == VMFR_STANDBY && !mcu_reset_n && !drive_enable;
    endproperty
    a_stby: assert property (p_stby) else $error("standby not entered");
    property p_bat_ov;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_BAT_OV] && !battery_ov_mask && !want_stby |=> state == VMFR_RESET;
    endproperty
    a_bat_ov: assert property (p_bat_ov) else $error("battery ov reset missing");
    property p_pre;
        @(posedge ref_clk) disable iff (reset)
        !(want_stby || want_rst || want_drv_off) |=> state == VMFR_ACTIVE && drive_enable;
    endproperty
    a_pre: assert property (p_pre) else $error("spurious action");
    property p_can_ov;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_CAN_OV] |=> !drive_enable && monitor_status_b[`VMFR_B_CAN_OV];
    endproperty
    a_can_ov: assert property (p_can_ov) else $error("can ov not handled");
    property p_io_uv;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_IO_UV] |=> state != VMFR_ACTIVE && !mcu_reset_n;
    endproperty
    a_io_uv: assert property (p_io_uv) else $error("io uv not handled");
    property p_core;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_CORE_OV] && core_fault_action_en |=> !drive_enable;
    endproperty
    a_core: assert property (p_core) else $error("core ov not handled");
    property p_por;
        @(posedge ref_clk) disable iff (reset)
        $rose(want_por) |=> power_on_reset && state == VMFR_STANDBY;
    endproperty
    a_por: assert property (p_por) else $error("power-on reset missing");
    property p_flag;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> monitor_status_a[`VMFR_A_BAT_UV] == $past(c[`VMFR_I_BAT_UV]);
    endproperty
    a_flag: assert property (p_flag) else $error("flag mismatch");
    property p_io_ov;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_IO_OV] |=> !drive_enable && monitor_status_b[`VMFR_B_IO_OV];
    endproperty
    a_io_ov: assert property (p_io_ov) else $error("io ov not handled");
    property p_core_uv;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_CORE_UV] && core_fault_action_en && !want_stby
            |=> state == VMFR_RESET && !mcu_reset_n && !drive_enable;
    endproperty
    a_core_uv: assert property (p_core_uv) else $error("core uv not handled");
    property p_sns;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_SNS_UV] |=> safety_status_a[`VMFR_S_SNS_UV];
    endproperty
    a_sns: assert property (p_sns) else $error("sensor uv flag missing");
    property p_regoff;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_PL_OV] |=> regulators_off && state == VMFR_STANDBY;
    endproperty
    a_regoff: assert property (p_regoff) else $error("pump low ov not handled");
    property p_ma;
        @(posedge ref_clk) disable iff (reset)
        c[`VMFR_I_MA_UV] || c[`VMFR_I_MA_OV] |=> monitor_status_a[`VMFR_A_MA] && power_on_reset;
    endproperty
    a_ma: assert property (p_ma) else $error("monitor analog fault not handled");
    // Reference fault goes through its register stage before the action
    sequence s_ref_seen;
        ref_mismatch ##1 ref_clean;
    endsequence
    property p_ref;
        @(posedge ref_clk) disable iff (reset)
        s_ref_seen |=> state == VMFR_STANDBY && !mcu_reset_n && !drive_enable;
    endproperty
    a_ref: assert property (p_ref) else $error("reference fault not handled");
endmodule // vmfr_monitor
`default_nettype wire

// *** vmfr_pkg.sv ***
package vmfr_pkg;
    typedef enum logic [1:0] {
        VMFR_ACTIVE = 2'b00,
        VMFR_RESET = 2'b01,
        VMFR_STANDBY = 2'b11
    } vmfr_state_type;
endpackage
